// File: shared/dst_pkg.sv
// Constants and types shared by the telegram bus master and its serial lanes
package dst_pkg;

  // ==========================================================================
  // Clock and line timing
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned DEF_BAUD = 9600;
  localparam int unsigned OVS = 16;
  localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_KHZ * 1000 / (OVS * DEF_BAUD) - 1);
  localparam int unsigned RESP_TMO_MS = 20;
  localparam int unsigned RESP_TMO_CYC = RESP_TMO_MS * CLK_KHZ;
  localparam int unsigned CHAR_BITS = 11;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] LAST_BIT = 4'ha;

  // ==========================================================================
  // Telegram layout
  localparam logic [7:0] STX_VAL = 8'h02;
  localparam logic [7:0] LEN_PROC = 8'h06;
  localparam logic [7:0] LEN_PARAM = 8'h0e;
  localparam logic [7:0] LEN_TEXT_FIX = 8'h0a;
  localparam logic [7:0] LEN_MIN = 8'h02;
  localparam logic [3:0] MAX_DATA = 4'hc;
  localparam logic [3:0] PROC_OFF = 4'h8;
  localparam logic [3:0] CMD_TEXT = 4'hf;
  localparam logic [7:0] TXT_RD_IDX = 8'h04;
  localparam logic [7:0] TXT_WR_IDX = 8'h05;
  localparam logic [7:0] ADR_LONG = 8'h80;
  localparam logic [7:0] ADR_SHORT_BC = 8'h20;

  // ==========================================================================
  // Register map of the master
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_BAUD = 6'h04;
  localparam logic [5:0] REG_TX0 = 6'h08;
  localparam logic [5:0] REG_TX1 = 6'h0c;
  localparam logic [5:0] REG_TX2 = 6'h10;
  localparam logic [5:0] REG_STAT = 6'h14;
  localparam logic [5:0] REG_RX0 = 6'h18;
  localparam logic [5:0] REG_RX1 = 6'h1c;
  localparam logic [5:0] REG_RX2 = 6'h20;
  localparam logic [5:0] REG_RXHDR = 6'h24;
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_KIND = 1;
  localparam int unsigned CTRL_LONG = 3;
  localparam int unsigned CTRL_BCAST = 4;
  localparam int unsigned CTRL_TXTWR = 5;
  localparam int unsigned CTRL_NODE = 8;

  typedef enum logic [1:0] {
    KIND_PROC = 2'b00,
    KIND_PARAM = 2'b01,
    KIND_TEXT = 2'b10
  } dst_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_RECV = 2'b10
  } dst_state_t;

endpackage : dst_pkg

// File: src/dst_master.sv
// Telegram bus master: AXI4-Lite register front end, framer and reply parser
// Summary of operation
// - Character is start, 8 data, parity, stop: 11 bit times
// - Parity makes ones in data plus parity even
// - Telegram opens with start marker 0x02
// - Then length, address, data bytes, check byte
// - Length is data count plus two: 6 or 14
// - Text telegram length is 10 plus text bytes; requests sent here are always 10 long and carry no text bytes
// - Short address: bit7 0, bit5 broadcast, else bits 4..0 node
// - Long address: bit7 1, bits 6..0 node, zero is broadcast
// - Check byte is XOR of telegram bytes from zero
// - Same three data layouts used in both directions
// - Process block: control then reference; reply status then frequency
// - Parameter block: id, index, value high, value low, process words
// - Id word: code in bits 15..12, number in 11..0
// - Value field two words; empty for reads, filled for writes
// - Text access uses code F, index high 4 read, 5 write
`timescale 1ns/1ps
module dst_master import dst_pkg::*; #(
  parameter int unsigned TMO_CYC = RESP_TMO_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic line_txd,
  output logic line_de,
  input wire logic line_rxd
);

  if (TMO_CYC < 2) begin : g_bad_tmo
    $error("TMO_CYC must be at least 2");
  end

  // ==========================================================================
  // Reset release
  logic [1:0] rst_s_q;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_s_q <= 2'b00;
    end else begin
      rst_s_q <= {rst_s_q[0], 1'b1};
    end
  end
  assign rst_n = rst_s_q[1];

  // ==========================================================================
  // State
  typedef struct packed {
    logic [1:0] sy;
    logic [15:0] div;
    logic tick;
    logic awok;
    logic wok;
    logic [5:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bval;
    logic rval;
    logic [31:0] rd;
    dst_kind_t kind;
    logic longf;
    logic bcast;
    logic txtw;
    logic [6:0] node;
    logic [15:0] baud;
    logic [31:0] tx0;
    logic [31:0] tx1;
    logic [31:0] tx2;
    logic done;
    logic perr;
    logic cerr;
    logic tmo;
    logic aerr;
    dst_state_t st;
    logic [7:0] pos;
    logic [7:0] tp;
    logic [7:0] xr;
    logic go;
    logic [7:0] txb;
    logic [31:0] tmr;
    logic [7:0] radr;
    logic [7:0] rlen;
    logic [11:0][7:0] rb;
  } dst_main_t;

  dst_main_t q;
  dst_main_t d;

  logic tx_busy;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_perr;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : lanes

  function automatic logic [7:0] data_cnt(input dst_kind_t k);
    logic [7:0] n;
    unique case (k)
      KIND_PROC: n = LEN_PROC - LEN_MIN;
      KIND_TEXT: n = LEN_TEXT_FIX - LEN_MIN;
      default: n = LEN_PARAM - LEN_MIN;
    endcase
    return n;
  endfunction : data_cnt

  function automatic logic [7:0] addr_byte(input logic longf, input logic bc,
                                           input logic [6:0] node);
    logic [7:0] a;
    if (longf) begin
      a = bc ? ADR_LONG : (ADR_LONG | {1'b0, node});
    end else begin
      a = bc ? ADR_SHORT_BC : {3'b000, node[4:0]};
    end
    return a;
  endfunction : addr_byte

  // Data byte k of the request, big-endian words in block order
  function automatic logic [7:0] data_byte(input logic [3:0] k);
    logic [95:0] w;
    logic [7:0] b;
    w = {q.tx0, q.tx1, q.tx2};
    b = w[8'(95 - 8 * k) -: 8];
    if (q.kind == KIND_TEXT && k == 4'h0) begin
      b = {CMD_TEXT, b[3:0]};
    end
    if (q.kind == KIND_TEXT && k == 4'h2) begin
      b = q.txtw ? TXT_WR_IDX : TXT_RD_IDX;
    end
    return b;
  endfunction : data_byte

  function automatic logic [7:0] tx_byte(input logic [7:0] p);
    logic [7:0] n;
    logic [7:0] b;
    logic [3:0] k;
    n = data_cnt(q.kind);
    k = 4'(p - 8'h03) + ((q.kind == KIND_PROC) ? PROC_OFF : 4'h0);
    if (p == 8'h00) begin
      b = STX_VAL;
    end else if (p == 8'h01) begin
      b = n + LEN_MIN;
    end else if (p == 8'h02) begin
      b = addr_byte(q.longf, q.bcast, q.node);
    end else if (p < n + 8'h03) begin
      b = data_byte(k);
    end else begin
      b = q.xr;
    end
    return b;
  endfunction : tx_byte

  function automatic logic [31:0] rd_reg(input logic [5:0] a);
    logic [31:0] r;
    unique case (a)
      REG_CTRL: r = 32'({q.node, 2'b00, q.txtw, q.bcast, q.longf, q.kind, 1'b0});
      REG_BAUD: r = {16'h0000, q.baud};
      REG_TX0: r = q.tx0;
      REG_TX1: r = q.tx1;
      REG_TX2: r = q.tx2;
      REG_STAT: r = 32'({q.aerr, q.tmo, q.cerr, q.perr, q.done, q.st != ST_IDLE});
      REG_RX0: r = {q.rb[0], q.rb[1], q.rb[2], q.rb[3]};
      REG_RX1: r = {q.rb[4], q.rb[5], q.rb[6], q.rb[7]};
      REG_RX2: r = {q.rb[8], q.rb[9], q.rb[10], q.rb[11]};
      REG_RXHDR: r = {16'h0000, q.rlen, q.radr};
      default: r = '0;
    endcase
    return r;
  endfunction : rd_reg

  // ==========================================================================
  // Next state
  logic aw_rdy;
  logic w_rdy;
  logic [7:0] last_pos;
  logic [7:0] b;
  logic [3:0] k;
  logic [31:0] bw;
  assign aw_rdy = !q.awok && !q.bval;
  assign w_rdy = !q.wok && !q.bval;
  assign last_pos = data_cnt(q.kind) + 8'h03;

  always_comb begin
    d = q;
    bw = '0;
    b = tx_byte(q.pos);
    k = 4'(q.pos - 8'h03);
    d.go = 1'b0;
    d.tick = 1'b0;
    d.sy = {q.sy[0], line_rxd};
    if (q.div >= q.baud) begin
      d.div = '0;
      d.tick = 1'b1;
    end else begin
      d.div = q.div + 16'h0001;
    end
    // Register bus
    if (s_axi_awvalid && aw_rdy) begin
      d.awok = 1'b1;
      d.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && w_rdy) begin
      d.wok = 1'b1;
      d.wd = s_axi_wdata;
      d.ws = s_axi_wstrb;
    end
    if (q.bval && s_axi_bready) begin
      d.bval = 1'b0;
    end
    if (s_axi_arvalid && !q.rval) begin
      d.rval = 1'b1;
      d.rd = rd_reg(s_axi_araddr);
    end
    if (q.rval && s_axi_rready) begin
      d.rval = 1'b0;
    end
    // Configuration is frozen while a telegram is in flight
    if (q.awok && q.wok && !q.bval) begin
      d.awok = 1'b0;
      d.wok = 1'b0;
      d.bval = 1'b1;
      if (q.st == ST_IDLE) begin
        if (q.awa == REG_CTRL) begin
          d.node = q.ws[1] ? q.wd[CTRL_NODE +: 7] : q.node;
          if (q.ws[0]) begin
            d.kind = dst_kind_t'(q.wd[CTRL_KIND +: 2]);
            d.longf = q.wd[CTRL_LONG];
            d.bcast = q.wd[CTRL_BCAST];
            d.txtw = q.wd[CTRL_TXTWR];
            if (q.wd[CTRL_GO]) begin
              d.st = ST_SEND;
              d.pos = '0;
              d.xr = '0;
              d.done = 1'b0;
              d.perr = 1'b0;
              d.cerr = 1'b0;
              d.tmo = 1'b0;
              d.aerr = 1'b0;
            end
          end
        end
        if (q.awa == REG_BAUD) begin
          bw = lanes({16'h0000, q.baud}, q.wd, q.ws);
          d.baud = bw[15:0];
        end
        if (q.awa == REG_TX0) begin
          d.tx0 = lanes(q.tx0, q.wd, q.ws);
        end
        if (q.awa == REG_TX1) begin
          d.tx1 = lanes(q.tx1, q.wd, q.ws);
        end
        if (q.awa == REG_TX2) begin
          d.tx2 = lanes(q.tx2, q.wd, q.ws);
        end
      end
    end
    // Telegram engine
    unique case (q.st)
      ST_IDLE: begin
        d.tmr = '0;
      end
      ST_SEND: begin
        if (!tx_busy && !q.go) begin
          if (q.pos <= last_pos) begin
            d.go = 1'b1;
            d.txb = b;
            d.tp = q.pos;
            d.xr = q.xr ^ b;
            d.pos = q.pos + 8'h01;
          end else if (q.bcast) begin
            d.st = ST_IDLE;
            d.done = 1'b1;
          end else begin
            d.st = ST_RECV;
            d.pos = '0;
            d.xr = '0;
            d.tmr = '0;
          end
        end
      end
      ST_RECV: begin
        d.tmr = q.tmr + 32'h1;
        if (q.tmr >= TMO_CYC - 1) begin
          d.tmo = 1'b1;
          d.done = 1'b1;
          d.st = ST_IDLE;
        end
        if (rx_valid) begin
          d.tmr = '0;
          d.perr = q.perr | rx_perr;
          d.xr = q.xr ^ rx_data;
          d.pos = q.pos + 8'h01;
          if (q.pos == 8'h00) begin
            // Hunt for the start marker
            d.pos = (rx_data == STX_VAL) ? 8'h01 : 8'h00;
            d.xr = (rx_data == STX_VAL) ? rx_data : 8'h00;
          end else if (q.pos == 8'h01) begin
            d.rlen = rx_data;
            if (rx_data < LEN_MIN) begin
              d.cerr = 1'b1;
              d.done = 1'b1;
              d.st = ST_IDLE;
            end
          end else if (q.pos == 8'h02) begin
            d.radr = rx_data;
            d.aerr = rx_data != addr_byte(q.longf, q.bcast, q.node);
          end else if (q.pos == q.rlen + 8'h01) begin
            d.cerr = q.xr != rx_data;
            d.done = 1'b1;
            d.st = ST_IDLE;
          end else if (k < MAX_DATA) begin
            // Text beyond the buffer still enters the check
            d.rb[k] = rx_data;
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.sy <= 2'b11;
      q.baud <= BAUD_DIV_RST;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = aw_rdy;
  assign s_axi_wready = w_rdy;
  assign s_axi_bvalid = q.bval;
  assign s_axi_bresp = 2'b00;
  assign s_axi_arready = !q.rval;
  assign s_axi_rvalid = q.rval;
  assign s_axi_rdata = q.rd;
  assign s_axi_rresp = 2'b00;

  // ==========================================================================
  // Serial lanes
  dst_ser_tx u_tx (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick16(q.tick),
    .start(q.go),
    .data(q.txb),
    .ser(line_txd),
    .busy(tx_busy)
  );

  // Half duplex: the receiver listens only after our own request is out
  dst_ser_rx u_rx (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick16(q.tick),
    .en(q.st == ST_RECV),
    .rxd(q.sy[1]),
    .valid(rx_valid),
    .data(rx_data),
    .perr(rx_perr)
  );

  assign line_de = tx_busy;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_start_marker: assert property (q.go && q.tp == 8'h00 |-> q.txb == STX_VAL)
    else $error("First byte is not the start marker");
  a_len_proc: assert property (q.go && q.tp == 8'h01 && q.kind == KIND_PROC
                               |-> q.txb == LEN_PROC)
    else $error("Process telegram length wrong");
  a_len_param: assert property (q.go && q.tp == 8'h01 && q.kind == KIND_PARAM
                                |-> q.txb == LEN_PARAM)
    else $error("Parameter telegram length wrong");
  a_len_text: assert property (q.go && q.tp == 8'h01 && q.kind == KIND_TEXT
                               |-> q.txb == LEN_TEXT_FIX)
    else $error("Text request length wrong");
  a_short_addr: assert property (q.go && q.tp == 8'h02 && !q.longf
                                 |-> !q.txb[7] && q.txb[5] == q.bcast)
    else $error("Short address byte malformed");
  a_long_bcast: assert property (q.go && q.tp == 8'h02 && q.longf && q.bcast
                                 |-> q.txb == ADR_LONG)
    else $error("Long broadcast address malformed");
  a_text_code: assert property (q.go && q.tp == 8'h03 && q.kind == KIND_TEXT
                                |-> q.txb[7:4] == CMD_TEXT)
    else $error("Text request code is not F");
  a_text_index: assert property (q.go && q.tp == 8'h05 && q.kind == KIND_TEXT
                                 |-> q.txb == (q.txtw ? TXT_WR_IDX : TXT_RD_IDX))
    else $error("Text index high byte wrong");
  a_check_zero: assert property (q.go && q.tp == last_pos |-> q.xr == 8'h00)
    else $error("Telegram XOR including check byte is not zero");
  a_bcast_quiet: assert property (q.st == ST_SEND && q.bcast |=> q.st != ST_RECV)
    else $error("Waiting for a reply to a broadcast");
  a_no_talk_rx: assert property (q.st == ST_RECV |-> !line_de ##1 !line_de)
    else $error("Line driven while awaiting reply");

  c_proc_sent: cover property (q.kind == KIND_PROC && q.go && q.tp == last_pos);
  c_param_done: cover property (q.kind == KIND_PARAM && $rose(q.done) && !q.tmo);
  c_bcast_done: cover property (q.bcast && $rose(q.done));
  c_timeout: cover property ($rose(q.tmo));

endmodule : dst_master

// File: src/dst_ser_rx.sv
// Serial character receiver with 16x oversampling and parity check
`timescale 1ns/1ps
module dst_ser_rx import dst_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tick16,
  input wire logic en,
  input wire logic rxd,
  output logic valid,
  output logic [7:0] data,
  output logic perr
);

  typedef struct packed {
    logic act;
    logic prev;
    logic [3:0] sub;
    logic [3:0] bitn;
    logic [8:0] sh;
    logic valid;
    logic [7:0] data;
    logic perr;
  } dst_rx_t;

  dst_rx_t q;
  dst_rx_t d;

  // ==========================================================================
  // Sampler
  always_comb begin
    d = q;
    d.valid = 1'b0;
    if (tick16) begin
      d.prev = rxd;
      if (!q.act) begin
        if (en && q.prev && !rxd) begin
          d.act = 1'b1;
          d.sub = '0;
          d.bitn = '0;
        end
      end else begin
        d.sub = q.sub + 4'h1;
        if (q.sub == ((q.bitn == 4'h0) ? OVS_MID : OVS_LAST)) begin
          d.sub = '0;
          d.bitn = q.bitn + 4'h1;
          if (q.bitn == 4'h0) begin
            // Glitch shorter than half a bit is not a start
            d.act = !rxd;
          end else if (q.bitn == LAST_BIT) begin
            d.act = 1'b0;
            d.valid = 1'b1;
            d.data = q.sh[7:0];
            d.perr = (^q.sh) | !rxd;
          end else begin
            d.sh = {rxd, q.sh[8:1]};
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign valid = q.valid;
  assign data = q.data;
  assign perr = q.perr;

endmodule : dst_ser_rx

// File: src/dst_ser_tx.sv
// Serial character transmitter: start, 8 data, even parity, stop
`timescale 1ns/1ps
module dst_ser_tx import dst_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tick16,
  input wire logic start,
  input wire logic [7:0] data,
  output logic ser,
  output logic busy
);

  typedef struct packed {
    logic busy;
    logic line;
    logic [10:0] sh;
    logic [3:0] bitn;
    logic [3:0] sub;
  } dst_tx_t;

  dst_tx_t q;
  dst_tx_t d;

  // ==========================================================================
  // Shifter
  always_comb begin
    d = q;
    if (!q.busy && start) begin
      d.busy = 1'b1;
      d.sh = {1'b1, ^data, data, 1'b0};
      d.bitn = '0;
      d.sub = '0;
    end else if (q.busy && tick16) begin
      d.sub = q.sub + 4'h1;
      if (q.sub == OVS_LAST) begin
        d.sh = {1'b1, q.sh[10:1]};
        d.bitn = q.bitn + 4'h1;
        if (q.bitn == LAST_BIT) begin
          d.busy = 1'b0;
        end
      end
    end
    d.line = d.busy ? d.sh[0] : 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.line <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign ser = q.line;
  assign busy = q.busy;

  // ==========================================================================
  // Checks
  logic [8:0] n_tk;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      n_tk <= '0;
    end else if (!q.busy && start) begin
      n_tk <= '0;
    end else if (q.busy && tick16) begin
      n_tk <= n_tk + 9'h001;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_parity_even: assert property (!q.busy && start |=> ^q.sh[9:1] == 1'b0)
    else $error("Parity bit does not make the ones count even");
  a_char_len: assert property ($fell(q.busy) |-> n_tk == 9'(CHAR_BITS * OVS))
    else $error("Character did not last eleven bit times");

endmodule : dst_ser_tx

// File: verif/dst_dev_model.sv
// Behavioural drive on the far end of the serial link
`timescale 1ns/1ps
module dst_dev_model (
  input wire logic clk_sys,
  input wire logic txd,
  input wire logic [6:0] own,
  input wire logic [1:0] mode,
  input wire logic [7:0] dly,
  output logic rxd,
  output logic [7:0] rx_len,
  output logic [7:0] rx_adr,
  output logic rx_err
);
  logic [7:0] b [16];
  logic [7:0] x;
  logic [7:0] y;
  logic pe;
  logic bc;
  logic mine;

  // ==========================================================================
  // Character level, 16 clocks a bit
  task automatic get(output logic [7:0] v);
    logic [10:0] s;
    @(negedge txd);
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 11; i++) begin
      s[i] = txd;
      // No wait after the stop bit, so a short gap is not missed
      if (i < 10) repeat (16) @(posedge clk_sys);
    end
    v = s[8:1];
    pe = pe | s[0] | ^s[9:1] | !s[10];
    x = x ^ v;
  endtask : get

  task automatic put(input logic [7:0] v);
    logic [10:0] s;
    s = {1'b1, ^v, v, 1'b0};
    y = y ^ v;
    for (int i = 0; i < 11; i++) begin
      rxd <= s[i];
      repeat (16) @(posedge clk_sys);
    end
  endtask : put

  // Parameter replies: unknown command gets a fault, sub-index from low byte only
  function automatic logic [7:0] rsp(input int i);
    logic ok;
    ok = b[3][7:4] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hd, 4'he, 4'hf};
    if (b[1] != 8'h0e) return ~b[i];
    if (i == 3) return ok ? ~b[3] : {4'h7, b[3][3:0]};
    if (i == 5) return 8'h00;
    if (i == 6) return b[6];
    if (i == 9 || i == 10) return ok ? ~b[i] : 8'h00;
    return ~b[i];
  endfunction : rsp

  // ==========================================================================
  // Telegram level; bad check or echo only when mode asks
  initial begin
    rxd = 1'b1;
    rx_err = 1'b0;
    rx_len = 8'h00;
    rx_adr = 8'h00;
    forever begin
      pe = 1'b0;
      x = 8'h00;
      y = 8'h00;
      get(b[0]);
      get(b[1]);
      for (int i = 2; i <= b[1] + 1 && i < 16; i++) get(b[i]);
      rx_len = b[1];
      rx_adr = b[2];
      rx_err = pe | (b[0] !== 8'h02) | (x !== 8'h00) | (b[1] > 8'h0e);
      bc = b[2][7] ? (b[2][6:0] == 7'h00) : b[2][5];
      mine = b[2][7] ? (b[2][6:0] == own) : (b[2][4:0] == own[4:0]);
      if (!rx_err && mine && !bc) begin
        repeat (dly) @(posedge clk_sys);
        put(8'h02);
        put(b[1]);
        put(mode == 2'h2 ? b[2] ^ 8'h01 : b[2]);
        for (int i = 3; i <= b[1]; i++) put(rsp(i));
        put(mode == 2'h1 ? ~y : y);
      end
    end
  end
endmodule : dst_dev_model

// File: verif/tb.sv
// Self-checking bench for the telegram bus master
`timescale 1ns/1ps
module tb import dst_pkg::*; ;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] awaddr = 6'h00;
  logic [5:0] araddr = 6'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, txd, de, rxd, m_err;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [6:0] own = 7'h01;
  logic [1:0] mode = 2'h0;
  logic [7:0] dly = 8'h14;
  logic [7:0] m_len, m_adr;
  int bad_count = 0;
  int samples_checked = 0;
  // Case code: mode[7:6] foreign[5] bcast[4] long[3] textwr[2] kind[1:0]
  logic [7:0] cs [10] = '{8'h00, 8'h09, 8'h0a, 8'h06, 8'h10, 8'h21, 8'h40, 8'h89, 8'h01, 8'h18};

  dst_master #(.TMO_CYC(4000)) u_dut (.clk_sys(clk_sys), .nrst(nrst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .line_txd(txd), .line_de(de), .line_rxd(rxd));
  dst_dev_model u_dev (.clk_sys(clk_sys), .txd(txd), .own(own), .mode(mode), .dly(dly),
    .rxd(rxd), .rx_len(m_len), .rx_adr(m_adr), .rx_err(m_err));

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Bus tasks: readiness sampled at the falling edge, released after the taking edge
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hf; wvalid <= 1'b1; bready <= 1'b1;
    fork
      begin do @(negedge clk_sys); while (!awready); @(posedge clk_sys); awvalid <= 1'b0; end
      begin do @(negedge clk_sys); while (!wready); @(posedge clk_sys); wvalid <= 1'b0; end
    join
    do @(negedge clk_sys); while (!bvalid);
    @(posedge clk_sys);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(negedge clk_sys); while (!arready);
    @(posedge clk_sys);
    arvalid <= 1'b0;
    do @(negedge clk_sys); while (!rvalid);
    d = rdata;
    @(posedge clk_sys);
    rready <= 1'b0;
  endtask : rd

  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string what);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic stop_test;
    $display("mismatches %0d, checks %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Expectations
  function automatic logic [7:0] exp_len(input logic [7:0] c);
    return c[1:0] == 2'd0 ? 8'h06 : (c[1:0] == 2'd1 ? 8'h0e : 8'h0a);
  endfunction : exp_len

  function automatic logic [7:0] exp_adr(input logic [7:0] c, input logic [6:0] nd);
    if (c[4]) return c[3] ? 8'h80 : 8'h20;
    if (c[3]) return {1'b1, nd};
    return {3'h0, nd[4:0]};
  endfunction : exp_adr

  function automatic logic [31:0] exp_stat(input logic [7:0] c);
    return c[4] ? 32'h02 : c[5] ? 32'h12 : c[6] ? 32'h0a : c[7] ? 32'h22 : 32'h02;
  endfunction : exp_stat

  function automatic logic [31:0] exp_rx(input logic [7:0] c, input int i,
                                         input logic [31:0] t [3]);
    logic ok;
    ok = t[0][31:28] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hd, 4'he, 4'hf};
    if (c[1:0] == 2'd0) return ~t[2];
    if (c[1:0] == 2'd1 && i == 0)
      return {ok ? ~t[0][31:24] : {4'h7, t[0][27:24]}, ~t[0][23:16], 8'h00, t[0][7:0]};
    if (c[1:0] == 2'd1 && i == 1) return ok ? ~t[1] : {~t[1][31:16], 16'h0000};
    if (c[1:0] == 2'd1) return ~t[2];
    if (i == 0) return ~{4'hf, t[0][27:16], (c[2] ? 8'h05 : 8'h04), t[0][7:0]};
    return ~t[1];
  endfunction : exp_rx

  always @(negedge clk_sys) if (txd === 1'b0) chk(32'h1, {31'h0, de}, "driver enable");

  initial begin
    repeat (100000) @(posedge clk_sys);
    bad_count++;
    stop_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] tx [3];
    logic [31:0] d;
    logic [31:0] st;
    logic [7:0] c;
    logic [6:0] nd;
    d = $urandom(32'h4e69);
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(REG_BAUD, d);
    chk({16'h0, BAUD_DIV_RST}, d, "baud reset");
    wr(6'h3c, 32'hffffffff);
    rd(6'h3c, d);
    chk(32'h0, d, "unmapped");
    wr(REG_BAUD, 32'h0);
    foreach (cs[k]) begin
      c = cs[k];
      own <= 7'($urandom_range(c[3] ? 126 : 31, 1));
      mode <= c[7:6];
      dly <= 8'($urandom_range(200, 20));
      for (int i = 0; i < 3; i++) begin
        tx[i] = $urandom;
        if (i == 0) tx[0][31:30] = {1'b0, c[3]};
        wr(REG_TX0 + 6'(4 * i), tx[i]);
      end
      nd = c[5] ? own ^ 7'h01 : own;
      wr(REG_CTRL, {17'h0, nd, 2'b00, c[2], c[4], c[3], c[1:0], 1'b1});
      st = 32'h0;
      for (int n = 0; n < 20000 && st[1] !== 1'b1; n++) rd(REG_STAT, st);
      chk(exp_stat(c), st, "status");
      chk({24'h0, exp_len(c)}, {24'h0, m_len}, "sent length");
      chk({24'h0, exp_adr(c, nd)}, {24'h0, m_adr}, "sent address");
      chk(32'h0, {31'h0, m_err}, "sent framing");
      if (exp_stat(c) == 32'h02 && !c[4]) begin
        rd(REG_RXHDR, d);
        chk({16'h0, exp_len(c), exp_adr(c, nd)}, d, "reply header");
        for (int i = 0; i < (c[1:0] == 2'd0 ? 1 : (c[1:0] == 2'd1 ? 3 : 2)); i++) begin
          rd(REG_RX0 + 6'(4 * i), d);
          chk(exp_rx(c, i, tx), d, "reply word");
        end
      end
    end
    stop_test();
  end
endmodule : tb
